/* rtl/gpt_channel.sv */
// one delay timer channel: input combination, truth tables and interval timing
// assumes the parent supplies a one-cycle one-second tick and a power-up marker
`default_nettype none
module gpt_channel
#(
  parameter int unsigned INTERVAL_W = gpt_pkg::INTERVAL_W
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic power_up_i,
  input wire logic [gpt_pkg::SRC_COUNT-1:0] sources_i,
  input wire gpt_pkg::gpt_config_t cfg_i,
  output logic out_o
);
  // selected sources
  logic src_a;
  logic src_b;
  logic src_r;
  logic [2:0] tbl_idx;
  logic timing_in;
  logic reset_in;
  // elapsed seconds and output state
  logic [INTERVAL_W-1:0] count_q;
  logic [INTERVAL_W-1:0] count_d;
  logic out_q;
  logic out_d;

  // source selection and logic combination
  always_comb
  begin
    src_a = sources_i[cfg_i.sel_a];
    src_b = sources_i[cfg_i.sel_b];
    src_r = sources_i[cfg_i.sel_reset];
    tbl_idx = {src_r, src_b, src_a}; // all low picks term 0 of each table
    if (cfg_i.logic_select)
    begin
      timing_in = cfg_i.timing_table[tbl_idx];
      reset_in = cfg_i.reset_table[tbl_idx];
    end
    else
    begin
      timing_in = src_a & src_b;
      reset_in = src_r;
    end
  end

  // next count and output
  always_comb
  begin
    count_d = count_q;
    out_d = out_q;
    if (reset_in)
    begin
      count_d = '0;
      out_d = 1'b0;
    end
    else if (cfg_i.behaviour == gpt_pkg::GPT_DELAY_OFF)
    begin
      if (timing_in)
      begin
        out_d = 1'b1;
        count_d = '0;
      end
      else if (out_q)
      begin
        // a zero interval drops at once
        if (count_q >= cfg_i.interval)
          out_d = 1'b0;
        else if (tick_i)
          count_d = count_q + 1'b1;
      end
    end
    else
    begin
      if (!timing_in)
      begin
        out_d = 1'b0;
        count_d = '0;
      end
      else if (power_up_i && cfg_i.behaviour == gpt_pkg::GPT_DELAY_ON_INIT)
        out_d = 1'b1;
      else if (!out_q)
      begin
        if (count_q >= cfg_i.interval)
          out_d = 1'b1;
        else if (tick_i)
          count_d = count_q + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;
endmodule : gpt_channel
`default_nettype wire

/* rtl/gpt_pkg.sv */
// package for the general purpose delay timers: modes, timing counts, config carrier
// assumes a single 100 MHz clock and a one-second tick derived inside the timer block
`default_nettype none
package gpt_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned NUM_TIMERS = 2;
  localparam int unsigned NUM_INPUTS = 3;
  localparam int unsigned TABLE_TERMS = 8;
  localparam int unsigned INTERVAL_W = 16;
  localparam int unsigned SRC_SEL_W = 4;
  localparam int unsigned SRC_COUNT = 16;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 16'h0000;
  localparam logic [TABLE_TERMS-1:0] TABLE_RST = 8'h00;

  // timer behaviour codes
  typedef enum logic [1:0]
  {
    GPT_DELAY_ON = 2'h0,
    GPT_DELAY_ON_INIT = 2'h1,
    GPT_DELAY_OFF = 2'h2
  } gpt_behaviour_t;

  // per-timer configuration
  typedef struct packed
  {
    logic [INTERVAL_W-1:0] interval;
    gpt_behaviour_t behaviour;
    logic logic_select;
    logic [SRC_SEL_W-1:0] sel_a;
    logic [SRC_SEL_W-1:0] sel_b;
    logic [SRC_SEL_W-1:0] sel_reset;
    logic [TABLE_TERMS-1:0] timing_table;
    logic [TABLE_TERMS-1:0] reset_table;
  } gpt_config_t;
endpackage : gpt_pkg
`default_nettype wire

/* rtl/gpt_timers.sv */
// top of the two general purpose delay timers with a one-second tick divider
// assumes sources are synchronous and configuration is held steady by the drive
//
// Contract
// - two independent timers with own settings
// - three inputs selected from internal sources
// - delay-on: rise after interval, fall immediately
// - delay-on-init: skip timing at power-up
// - delay-off: rise immediately, fall after interval
// - interval counted in one-second ticks
// - mode selects delay-on or delay-off
// - logic select: standard or custom tables
// - custom: three-input table drives timing
// - index picks term; all-low picks first
// - reset has own same-indexed table
`default_nettype none
module gpt_timers
#(
  parameter int unsigned TICK_CYCLES = gpt_pkg::TICK_CYCLES
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [gpt_pkg::SRC_COUNT-1:0] sources_i,
  input wire gpt_pkg::gpt_config_t first_timer_cfg_i,
  input wire gpt_pkg::gpt_config_t second_timer_cfg_i,
  output logic [gpt_pkg::NUM_TIMERS-1:0] timer_out_o
);
  // divider state; wide enough for a full second
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic tick;
  // power-up marker: high for the first cycle after reset release
  logic power_up_q;
  logic power_up_d;
  gpt_pkg::gpt_config_t cfg [gpt_pkg::NUM_TIMERS];

  assign cfg[0] = first_timer_cfg_i;
  assign cfg[1] = second_timer_cfg_i;

  // one-second enable pulse
  always_comb
  begin
    tick = (div_q == 32'(TICK_CYCLES - 1));
    div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
    power_up_d = 1'b0;
  end

  // divider and power-up registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q <= 32'h0000_0000;
      power_up_q <= 1'b1;
    end
    else
    begin
      div_q <= div_d;
      power_up_q <= power_up_d;
    end
  end

  // one channel per timer, each fully independent
  for (genvar i = 0; i < gpt_pkg::NUM_TIMERS; i++)
  begin : g_timer
    gpt_channel #(.INTERVAL_W(gpt_pkg::INTERVAL_W)) u_chan
    (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .power_up_i(power_up_q),
      .sources_i(sources_i),
      .cfg_i(cfg[i]),
      .out_o(timer_out_o[i])
    );
  end
endmodule : gpt_timers
`default_nettype wire

/* test/gpt_timers_props.sv */
// checker on the first timer channel
// assumes config held steady between resets
`default_nettype none
module gpt_timers_props #(parameter int unsigned TICK_CYCLES = 10)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [15:0] sources_i,
  input wire gpt_pkg::gpt_config_t first_timer_cfg_i,
  input wire logic [1:0] timer_out_o
);
  gpt_pkg::gpt_config_t c;
  logic [2:0] x; // table index {reset, b, a}
  logic a, r, o, f_q;
  int b, n, h_q, l_q; // mode, interval in cycles, run lengths
  assign c = first_timer_cfg_i;
  assign o = timer_out_o[0];
  assign b = c.behaviour;
  assign x = {sources_i[c.sel_reset], sources_i[c.sel_b], sources_i[c.sel_a]};
  assign a = c.logic_select ? c.timing_table[x] : &x[1:0];
  assign r = c.logic_select ? c.reset_table[x] : x[2];
  assign n = c.interval * TICK_CYCLES;
  // one tick of margin: tick phase is free running
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    h_q <= rst_i ? 0 : (a && !r ? h_q + 1 : 0);
    l_q <= rst_i ? 0 : (a ? 0 : l_q + 1);
    f_q <= rst_i;
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_rst_low: assert property (r |=> !o) else $error("reset");
  a_on_fall: assert property (b < 2 && !a |=> !o) else $error("fall");
  a_off_rise: assert property (b == 2 && a && !r |=> o) else $error("rise");
  a_on_wait: assert property (b == 0 && $rose(o) |-> h_q + TICK_CYCLES >= n)
    else $error("early");
  a_on_late: assert property (b < 2 && h_q > n + TICK_CYCLES + 2 |-> o) else $error("late");
  a_off_wait: assert property (b == 2 && $fell(o) && !$past(r) |-> l_q + TICK_CYCLES >= n)
    else $error("early");
  a_off_late: assert property (b == 2 && l_q > n + TICK_CYCLES + 2 |-> !o) else $error("late");
  a_init_skip: assert property (b == 1 && f_q && a && !r |=> o) else $error("skip");
endmodule : gpt_timers_props
`default_nettype wire

/* test/gpt_src_model.sv */
// drive flags feeding the timers
// assumes the bench sets them at falling edges
`default_nettype none
module gpt_src_model
(
  input wire logic [15:0] want_i,
  output logic [15:0] sources_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign sources_o = want_i; // synchronous levels
endmodule : gpt_src_model
`default_nettype wire

/* test/test_gpt_timers.sv */
// bench for the two delay timers
// assumes a 10-cycle tick to keep runs short
`default_nettype none
module test_gpt_timers;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, rst_i = 1'h1;
  logic [15:0] w = 16'h0, s;
  logic [1:0] q;
  logic [31:0] lf = 32'h87e1d66b;
  gpt_pkg::gpt_config_t c1 = '0, c2 = '0;
  int fails = 0, tests_run = 0, cy = 0;
  always #5 clock_i = ~clock_i;
  gpt_src_model gpt_src_model_i (.want_i(w), .sources_o(s));
  gpt_timers #(.TICK_CYCLES(10)) gpt_timers_i (.clock_i(clock_i), .rst_i(rst_i), .sources_i(s),
    .first_timer_cfg_i(c1), .second_timer_cfg_i(c2), .timer_out_o(q));
  function automatic logic [31:0] rn();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rn
  // custom tables: timing term masked by reset term
  function automatic logic ex(gpt_pkg::gpt_config_t c);
    logic [2:0] x;
    x = {s[c.sel_reset], s[c.sel_b], s[c.sel_a]};
    return c.timing_table[x] & ~c.reset_table[x];
  endfunction : ex
  task automatic ck(string t, logic e, logic v);
    tests_run++;
    if (v !== e)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", t, e, v);
    end
  endtask : ck
  // set flags at a falling edge, then wait
  task automatic go(int k, logic [15:0] v);
    w = v;
    repeat (k) @(negedge clock_i);
  endtask : go
  task automatic rs(logic [15:0] v);
    rst_i = 1'h1;
    go(1, v);
    rst_i = 1'h0;
  endtask : rs
  task automatic close_out();
    $display("compared %0d mismatched %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clock_i)
    if (++cy > 3000)
    begin
      fails++;
      close_out();
    end
  initial
  begin
    go(4, 16'h0);
    rst_i = 1'h0;
    for (int k = 0; k < 2; k++)
    begin
      c1 = '0;
      c1.sel_b = 4'h1;
      c1.sel_reset = 4'h2;
      c1.interval = 16'h2;
      c1.behaviour = gpt_pkg::gpt_behaviour_t'(2 * k);
      c2 = c1;
      c2.behaviour = gpt_pkg::gpt_behaviour_t'(2 - 2 * k);
      rs(16'h0);
      go(5, 16'h3);
      ck("on early", 1'h0, q[k]);
      ck("off rise", 1'h1, q[1-k]);
      go(40, 16'h3);
      ck("on rise", 1'h1, q[k]);
      go(2, 16'h7);
      ck("reset", 1'h0, |q);
      go(40, 16'h3);
      go(5, 16'h0);
      ck("on fall", 1'h0, q[k]);
      ck("off hold", 1'h1, q[1-k]);
      go(40, 16'h0);
      ck("off fall", 1'h0, q[1-k]);
      $display("delay test %0d done", k);
    end
    c1.behaviour = gpt_pkg::GPT_DELAY_ON_INIT;
    c1.interval = 16'h5;
    rs(16'h3);
    go(2, 16'h3);
    ck("init skip", 1'h1, q[0]);
    c1.behaviour = gpt_pkg::GPT_DELAY_ON;
    rs(16'h3);
    go(2, 16'h3);
    ck("no skip", 1'h0, q[0]);
    $display("power-up test done");
    c1 = '0;
    c1.logic_select = 1'h1;
    c2 = c1;
    for (int i = 0; i < 30; i++)
    begin
      {c1.sel_a, c1.sel_b, c1.sel_reset, c1.timing_table, c1.reset_table} = 28'(rn());
      {c2.sel_a, c2.sel_b, c2.sel_reset, c2.timing_table, c2.reset_table} = 28'(rn());
      if (i == 0)
        {c1.timing_table, c1.reset_table} = 16'h0100;
      rs(i ? 16'(rn()) : 16'h0);
      go(3, w);
      ck("table one", ex(c1), q[0]);
      ck("table two", ex(c2), q[1]);
    end
    $display("table test done");
    close_out();
  end
endmodule : test_gpt_timers
bind gpt_timers gpt_timers_props #(.TICK_CYCLES(TICK_CYCLES)) gpt_timers_props_i
  (.clock_i(clock_i), .rst_i(rst_i), .sources_i(sources_i),
  .first_timer_cfg_i(first_timer_cfg_i), .timer_out_o(timer_out_o));
`default_nettype wire
